// [slep_pkg.sv]
// Package of constants for the error and pointer register block
package slep_pkg;
    // Bit positions within the error and pointer register
    localparam int TX_CLK_LOSS_BIT  = 0;
    localparam int RX_CLK_LOSS_BIT  = 1;
    localparam int TX_OVERRUN_BIT   = 2;
    localparam int RX_OVERRUN_BIT   = 3;
    localparam int TX_NXM_BIT       = 4;
    localparam int RX_NXM_BIT       = 5;
    localparam int RECEIVE_BLOCK_CHECK_ACCUM_BIT       = 6;
    localparam int PTR_LSB          = 8;
    localparam int PTR_MSB          = 11;
    // Mask of bits software may write and read back
    localparam logic [15:0] ERR_WR_MASK = 16'h0F7F;
    localparam logic [15:0] ERR_RESET   = 16'h0000;
    // Secondary selections belonging to optional expanders
    localparam logic [3:0] SEL_CHAR_DET = 4'h8;
    localparam logic [3:0] SEL_SYNC     = 4'h9;
    localparam logic [3:0] SEL_RECEIVE_BLOCK_CHECK_ACCUM   = 4'hD;
    localparam logic [3:0] SEL_TX_BCC   = 4'hE;
    localparam logic [3:0] SEL_POLY     = 4'hF;
    // Clock loss timeout: 0.5 s at 4 ns per cycle
    localparam longint CLK_LOSS_NS     = 64'd500000000;
    localparam longint MCLK_PERIOD_NS  = 64'd4;
    localparam longint CLK_LOSS_CYCLES = CLK_LOSS_NS / MCLK_PERIOD_NS;
    // Service window in characters for narrow characters
    localparam logic [1:0] SVC_CHARS_NARROW = 2'h2;
    localparam logic [1:0] SVC_CHARS_WIDE   = 2'h1;
    localparam logic [3:0] NARROW_LIMIT     = 4'h9;
endpackage : slep_pkg

// [slep_sec_mem.sv]
// Sixteen word secondary register store with registered read data
`timescale 1ns/10ps
module slep_sec_mem
(
    input  wire logic        mclk_i,
    input  wire logic        we_i,
    input  wire logic [3:0]  addr_i,
    input  wire logic [15:0] wdata_i,
    output logic      [15:0] rdata_o
);
    logic [15:0] mem [16];

    // Plain storage, no reset so it maps onto small RAM
    always_ff @(posedge mclk_i)
    begin
        if (we_i)
        begin
            mem[addr_i] <= wdata_i;
        end
        rdata_o <= mem[addr_i];
    end
endmodule : slep_sec_mem

// [slep_err_ptr.sv]
// Error and pointer status register with secondary register window
// Behaviour
// - Set Tx or Rx clock loss bit when that side's clock stops while active.
// - Clock loss also sets if run asserted without clock, or clock gone 0.5 s.
// - Setting a clock loss bit clears that direction's run flip-flop.
// - Set latency bit when transfer request unserviced within one character time, or two for narrow characters.
// - Setting a latency bit clears that direction's run flip-flop.
// - Set non-existent memory bit on unanswered transfer; clear that run.
// - Error bits are read/write, cleared by initialize and master clear.
// - Any error bit requests an interrupt on vector B when enabled.
// - With block check option, bit 06 sets on received check mismatch.
// - A block check mismatch clears the receive block check accumulator.
// - A block check mismatch leaves receive run unchanged.
// - Bits 08 to 11 point at one of 16 secondary registers.
// - The error and pointer register accepts word and byte accesses.
// - Secondaries of uninstalled options read as zero.
`timescale 1ns/10ps
module slep_err_ptr
#(
    parameter longint CLK_LOSS_CYCLES = slep_pkg::CLK_LOSS_CYCLES,
    parameter bit     BCC_OPTION      = 1'b1,
    parameter bit     CHAR_OPTION     = 1'b1
)
(
    input  wire logic        mclk_i,
    input  wire logic        resetn_i,
    input  wire logic        bus_init_i,
    input  wire logic        master_clear_i,
    // Register port: error register and select 6 window
    input  wire logic        err_sel_i,
    input  wire logic        sec_sel_i,
    input  wire logic        wr_i,
    input  wire logic        rd_i,
    input  wire logic [1:0]  byte_en_i,
    input  wire logic [15:0] wdata_i,
    output logic      [15:0] rdata_o,
    output logic             rvalid_o,
    // Run flip-flop control from the control registers
    input  wire logic        tx_run_set_i,
    input  wire logic        rx_run_set_i,
    input  wire logic        error_interrupt_enable_i,
    // Line and transfer status
    input  wire logic        tx_clk_edge_i,
    input  wire logic        rx_clk_edge_i,
    input  wire logic        tx_direct_transfer_request_i,
    input  wire logic        rx_direct_transfer_request_i,
    input  wire logic        tx_transfer_grant_i,
    input  wire logic        rx_transfer_grant_i,
    input  wire logic        tx_char_done_i,
    input  wire logic        rx_char_done_i,
    input  wire logic [3:0]  char_bits_i,
    input  wire logic        tx_no_memory_i,
    input  wire logic        rx_no_memory_i,
    input  wire logic        receive_block_check_accum_mismatch_i,
    output logic             tx_run_o,
    output logic             rx_run_o,
    output logic             receive_block_check_accum_clr_o,
    output logic             irq_vector_b_o
);
    localparam int CW = 28;
    localparam logic [CW-1:0] LOSS_LIM = CW'(CLK_LOSS_CYCLES);

    typedef struct packed {
        logic [15:0]   err;
        logic          tx_run;
        logic          rx_run;
        logic [CW-1:0] tx_idle;
        logic [CW-1:0] rx_idle;
        logic [1:0]    tx_wait;
        logic [1:0]    rx_wait;
        logic          bcc_clr;
        logic          irq;
        logic [15:0]   rdata;
        logic          rvalid;
        logic          sec_rd;
        logic          sec_zero;
    } slep_state_t;

    slep_state_t st;
    slep_state_t next_st;
    logic [15:0] sec_rdata;
    logic        sec_we;

    // Uninstalled option secondaries read as zero
    function automatic logic sec_absent(input logic [3:0] sel);
        logic bcc_sel;
        logic chr_sel;
        bcc_sel = (sel == slep_pkg::SEL_RECEIVE_BLOCK_CHECK_ACCUM) || (sel == slep_pkg::SEL_TX_BCC)
                  || (sel == slep_pkg::SEL_POLY);
        chr_sel = (sel == slep_pkg::SEL_CHAR_DET) || (sel == slep_pkg::SEL_SYNC);
        return (bcc_sel && !BCC_OPTION) || (chr_sel && !CHAR_OPTION);
    endfunction : sec_absent

    // Idle counter: saturates at the loss limit, restarts on clock edge
    function automatic logic [CW-1:0] idle_step(input logic [CW-1:0] c,
                                                input logic edge_seen);
        if (edge_seen)
            return '0;
        else if (c >= LOSS_LIM)
            return c;
        else
            return c + CW'(1);
    endfunction : idle_step

    // Pending transfer age in characters; window is one or two characters
    function automatic logic [1:0] wait_step(input logic [1:0] w,
                                             input logic req,
                                             input logic grant,
                                             input logic done);
        if (!req || grant)
            return 2'h0;
        else if (done && w != 2'h3)
            return w + 2'h1;
        else
            return w;
    endfunction : wait_step

    logic [1:0] svc_limit;
    logic [3:0] ptr;
    assign svc_limit = (char_bits_i < slep_pkg::NARROW_LIMIT) ? slep_pkg::SVC_CHARS_NARROW
                                                               : slep_pkg::SVC_CHARS_WIDE;
    assign ptr       = st.err[slep_pkg::PTR_MSB:slep_pkg::PTR_LSB];
    // Word only window; byte writes are dropped
    assign sec_we    = sec_sel_i && wr_i && (byte_en_i == 2'h3) && !sec_absent(ptr);

    slep_sec_mem u_sec
    (
        .mclk_i  (mclk_i),
        .we_i    (sec_we),
        .addr_i  (ptr),
        .wdata_i (wdata_i),
        .rdata_o (sec_rdata)
    );

    // Next state of the whole block
    always_comb
    begin
        logic [15:0] e;
        logic [15:0] newly;
        logic        tx_kill;
        logic        rx_kill;
        e       = '0;
        newly   = '0;
        tx_kill = 1'b0;
        rx_kill = 1'b0;
        next_st = st;
        e       = st.err;

        // Software write with byte lanes
        if (err_sel_i && wr_i)
        begin
            if (byte_en_i[0])
                e[7:0] = wdata_i[7:0] & slep_pkg::ERR_WR_MASK[7:0];
            if (byte_en_i[1])
                e[15:8] = wdata_i[15:8] & slep_pkg::ERR_WR_MASK[15:8];
        end

        next_st.tx_idle = idle_step(st.tx_idle, tx_clk_edge_i);
        next_st.rx_idle = idle_step(st.rx_idle, rx_clk_edge_i);
        next_st.tx_wait = wait_step(st.tx_wait, tx_direct_transfer_request_i,
                                    tx_transfer_grant_i, tx_char_done_i);
        next_st.rx_wait = wait_step(st.rx_wait, rx_direct_transfer_request_i,
                                    rx_transfer_grant_i, rx_char_done_i);

        // Hardware detection; set beats a same-cycle software clear
        if (st.tx_run && st.tx_idle >= LOSS_LIM)
            newly[slep_pkg::TX_CLK_LOSS_BIT] = 1'b1;
        if (st.rx_run && st.rx_idle >= LOSS_LIM)
            newly[slep_pkg::RX_CLK_LOSS_BIT] = 1'b1;
        if (st.tx_run && st.tx_wait >= svc_limit)
            newly[slep_pkg::TX_OVERRUN_BIT] = 1'b1;
        if (st.rx_run && st.rx_wait >= svc_limit)
            newly[slep_pkg::RX_OVERRUN_BIT] = 1'b1;
        if (tx_no_memory_i)
            newly[slep_pkg::TX_NXM_BIT] = 1'b1;
        if (rx_no_memory_i)
            newly[slep_pkg::RX_NXM_BIT] = 1'b1;
        if (receive_block_check_accum_mismatch_i && BCC_OPTION)
            newly[slep_pkg::RECEIVE_BLOCK_CHECK_ACCUM_BIT] = 1'b1;
        e = e | newly;

        // Any set run-stopping error drops run, written or detected alike
        tx_kill = e[slep_pkg::TX_CLK_LOSS_BIT] | e[slep_pkg::TX_OVERRUN_BIT]
                | e[slep_pkg::TX_NXM_BIT];
        rx_kill = e[slep_pkg::RX_CLK_LOSS_BIT] | e[slep_pkg::RX_OVERRUN_BIT]
                | e[slep_pkg::RX_NXM_BIT];
        // Block check error deliberately not in rx_kill
        next_st.tx_run = (st.tx_run | tx_run_set_i) & ~tx_kill;
        next_st.rx_run = (st.rx_run | rx_run_set_i) & ~rx_kill;
        // Run asserted with no clock is caught once the idle limit passes
        if (tx_run_set_i && !st.tx_run)
            next_st.tx_idle = st.tx_idle;
        if (rx_run_set_i && !st.rx_run)
            next_st.rx_idle = st.rx_idle;

        next_st.bcc_clr = newly[slep_pkg::RECEIVE_BLOCK_CHECK_ACCUM_BIT];
        next_st.irq = error_interrupt_enable_i && (|e[6:0]);

        // Initialize and master clear wipe the error bits
        if (bus_init_i || master_clear_i)
        begin
            e = slep_pkg::ERR_RESET;
            next_st.tx_run = 1'b0;
            next_st.rx_run = 1'b0;
            next_st.irq    = 1'b0;
        end
        next_st.err = e;

        // Read path; secondary data arrives one cycle after the memory read
        next_st.rvalid   = 1'b0;
        next_st.sec_rd   = sec_sel_i && rd_i;
        next_st.sec_zero = sec_absent(ptr);
        if (err_sel_i && rd_i)
        begin
            next_st.rdata  = st.err;
            next_st.rvalid = 1'b1;
        end
        else if (st.sec_rd)
        begin
            next_st.rdata  = st.sec_zero ? 16'h0000 : sec_rdata;
            next_st.rvalid = 1'b1;
        end
    end

    // State register
    always_ff @(posedge mclk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            st <= '0;
        end
        else
        begin
            st <= next_st;
        end
    end

    assign rdata_o                         = st.rdata;
    assign rvalid_o                        = st.rvalid;
    assign tx_run_o                        = st.tx_run;
    assign rx_run_o                        = st.rx_run;
    assign receive_block_check_accum_clr_o = st.bcc_clr;
    assign irq_vector_b_o                  = st.irq;
endmodule : slep_err_ptr

// [slep_err_ptr_properties.sv]
// Checker of the error and pointer register block at its ports
`timescale 1ns/10ps
module slep_err_ptr_properties
(
    input wire logic mclk_i, resetn_i, bus_init_i, master_clear_i, err_sel_i, sec_sel_i,
    input wire logic rd_i, rvalid_o, tx_run_set_i, error_interrupt_enable_i, tx_no_memory_i,
    input wire logic rx_no_memory_i, receive_block_check_accum_mismatch_i, tx_run_o, rx_run_o, irq_vector_b_o,
    input wire logic receive_block_check_accum_clr_o
);
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!resetn_i);
    // Clears win over every other cause of error bits, run and request, so they gate the antecedents
    wire clr = bus_init_i | master_clear_i;
    wire en  = error_interrupt_enable_i;
    AST_TX_NXM: assert property (tx_no_memory_i && !tx_run_set_i |=> !tx_run_o)
        else $error("tx run kept after missing memory");
    AST_NXM_IRQ: assert property (tx_no_memory_i && !clr ##1 en && !clr |=> irq_vector_b_o)
        else $error("no error request after missing memory");
    AST_IRQ_MASK: assert property (!en |=> !irq_vector_b_o)
        else $error("error request while masked");
    AST_BCC_CLR: assert property (receive_block_check_accum_mismatch_i && !clr |=> receive_block_check_accum_clr_o)
        else $error("check accumulator not cleared");
    AST_BCC_RUN: assert property (receive_block_check_accum_mismatch_i && rx_run_o && !rx_no_memory_i && !clr
        |=> rx_run_o) else $error("rx run dropped on check mismatch");
    AST_ERR_RD: assert property (err_sel_i && rd_i && !sec_sel_i |=> rvalid_o)
        else $error("error register read not answered");
    AST_SEC_RD: assert property (sec_sel_i && rd_i && !err_sel_i |-> ##2 rvalid_o)
        else $error("secondary read not answered");
    AST_INIT: assert property (clr |=> !tx_run_o && !rx_run_o && !irq_vector_b_o)
        else $error("clear left run or request set");
    cover property (receive_block_check_accum_mismatch_i && rx_run_o);
    cover property (sec_sel_i && rd_i);
    cover property ($fell(tx_run_o));
endmodule : slep_err_ptr_properties

bind slep_err_ptr slep_err_ptr_properties u_props
(
    .mclk_i(mclk_i), .resetn_i(resetn_i), .bus_init_i(bus_init_i),
    .master_clear_i(master_clear_i), .err_sel_i(err_sel_i), .sec_sel_i(sec_sel_i),
    .rd_i(rd_i), .rvalid_o(rvalid_o), .tx_run_set_i(tx_run_set_i),
    .error_interrupt_enable_i(error_interrupt_enable_i), .tx_no_memory_i(tx_no_memory_i),
    .rx_no_memory_i(rx_no_memory_i), .receive_block_check_accum_mismatch_i(receive_block_check_accum_mismatch_i),
    .tx_run_o(tx_run_o), .rx_run_o(rx_run_o), .irq_vector_b_o(irq_vector_b_o),
    .receive_block_check_accum_clr_o(receive_block_check_accum_clr_o)
);

// [slep_bus_partner.sv]
// Host memory model answering direct transfer requests after a set delay
`timescale 1ns/10ps
module slep_bus_partner
(
    input  wire logic       mclk_i, req_i, nxm_i,
    input  wire logic [7:0] delay_i,
    output logic            grant_o, no_memory_o
);
    logic [7:0] cnt = 8'h00;
    // A missing location never grants, so the requester has to give up
    always @(posedge mclk_i)
    begin
        grant_o     <= req_i && cnt == delay_i && !nxm_i;
        no_memory_o <= req_i && cnt == delay_i && nxm_i;
        cnt         <= (req_i && cnt != delay_i) ? cnt + 8'h01 : 8'h00;
    end
endmodule : slep_bus_partner

// [slep_err_ptr_tb.sv]
// Self-checking bench for the error and pointer register block
`timescale 1ns/10ps
module sync_line_error_pointer_register_tb_top;
    logic mclk_i = 1'h0, resetn_i = 1'h0, bus_init_i = 1'h0, master_clear_i = 1'h0, sd;
    logic err_sel_i = 1'h0, sec_sel_i = 1'h0, wr_i = 1'h0, rd_i = 1'h0, receive_block_check_accum_mismatch_i = 1'h0;
    logic error_interrupt_enable_i = 1'h0, tx_clk_edge_i = 1'h0, rx_clk_edge_i = 1'h0;
    logic tx_transfer_grant_i, rx_transfer_grant_i, tx_no_memory_i, rx_no_memory_i;
    logic rvalid_o, tx_run_o, rx_run_o, receive_block_check_accum_clr_o, irq_vector_b_o;
    logic [1:0]  byte_en_i = 2'h0, req = 2'h0, cdone = 2'h0, rset = 2'h0, nxm = 2'h0, clk_on = 2'h3;
    logic [3:0]  char_bits_i = 4'h8;
    logic [7:0]  dly = 8'h01;
    logic [15:0] wdata_i = 16'h0000, rdata_o, exp_err = 16'h0000, d, sec_m [16];
    int          error_cnt = 0, total_checks = 0, seed = 72, k;
    wire tx_direct_transfer_request_i = req[0], rx_direct_transfer_request_i = req[1];
    wire tx_char_done_i = cdone[0], rx_char_done_i = cdone[1];
    wire tx_run_set_i = rset[0], rx_run_set_i = rset[1];

    // Short loss limit keeps the clock loss cases inside the run time
    slep_err_ptr #(.CLK_LOSS_CYCLES(20), .CHAR_OPTION(1'b0)) dut
    (
        .mclk_i(mclk_i), .resetn_i(resetn_i), .bus_init_i(bus_init_i),
        .master_clear_i(master_clear_i), .err_sel_i(err_sel_i), .sec_sel_i(sec_sel_i),
        .wr_i(wr_i), .rd_i(rd_i), .byte_en_i(byte_en_i), .wdata_i(wdata_i),
        .rdata_o(rdata_o), .rvalid_o(rvalid_o), .tx_run_set_i(tx_run_set_i),
        .rx_run_set_i(rx_run_set_i), .error_interrupt_enable_i(error_interrupt_enable_i),
        .tx_clk_edge_i(tx_clk_edge_i), .rx_clk_edge_i(rx_clk_edge_i),
        .tx_direct_transfer_request_i(tx_direct_transfer_request_i),
        .rx_direct_transfer_request_i(rx_direct_transfer_request_i),
        .tx_transfer_grant_i(tx_transfer_grant_i), .rx_transfer_grant_i(rx_transfer_grant_i),
        .tx_char_done_i(tx_char_done_i), .rx_char_done_i(rx_char_done_i),
        .char_bits_i(char_bits_i), .tx_no_memory_i(tx_no_memory_i),
        .rx_no_memory_i(rx_no_memory_i), .receive_block_check_accum_mismatch_i(receive_block_check_accum_mismatch_i),
        .tx_run_o(tx_run_o), .rx_run_o(rx_run_o),
        .receive_block_check_accum_clr_o(receive_block_check_accum_clr_o),
        .irq_vector_b_o(irq_vector_b_o)
    );
    slep_bus_partner tx_mem (.mclk_i(mclk_i), .req_i(req[0]), .nxm_i(nxm[0]), .delay_i(dly),
        .grant_o(tx_transfer_grant_i), .no_memory_o(tx_no_memory_i));
    slep_bus_partner rx_mem (.mclk_i(mclk_i), .req_i(req[1]), .nxm_i(nxm[1]), .delay_i(dly),
        .grant_o(rx_transfer_grant_i), .no_memory_o(rx_no_memory_i));

    always #2 mclk_i = ~mclk_i;
    // Serial edges every other cycle; a stopped side models a dead line
    always @(negedge mclk_i)
    begin
        tx_clk_edge_i <= clk_on[0] & ~tx_clk_edge_i;
        rx_clk_edge_i <= clk_on[1] & ~rx_clk_edge_i;
    end

    task automatic chk(input logic [15:0] got, input logic [15:0] e);
        total_checks++;
        if (got !== e)
        begin
            error_cnt++;
            $display("FAIL %0t got %h expected %h", $time, got, e);
        end
    endtask : chk
    // One strobe cycle, then wait a bounded time for the read answer
    task automatic acc(input logic s, input logic w, input logic [1:0] be, input logic [15:0] v);
        @(negedge mclk_i);
        {err_sel_i, sec_sel_i, wr_i, rd_i, byte_en_i, wdata_i} = {~s, s, w, ~w, be, v};
        @(negedge mclk_i);
        {err_sel_i, sec_sel_i, wr_i, rd_i} = 4'h0;
        for (int i = 0; i < 4 && !w && rvalid_o !== 1'h1; i++) @(negedge mclk_i);
    endtask : acc
    task automatic rd(input logic s, input logic [15:0] e);
        acc(s, 1'h0, 2'h3, 16'h0000);
        chk({15'h0, rvalid_o}, 16'h0001);
        chk(rdata_o, e);
    endtask : rd
    task automatic wr_err(input logic [1:0] be, input logic [15:0] v);
        logic [15:0] m;
        m = {{8{be[1]}}, {8{be[0]}}} & slep_pkg::ERR_WR_MASK;
        exp_err = (exp_err & ~m) | (v & m);
        acc(1'h0, 1'h1, be, v);
    endtask : wr_err
    task automatic pulse_done(input logic s);
        cdone[s] = 1'h1;
        @(negedge mclk_i);
        cdone = 2'h0;
        repeat (2) @(negedge mclk_i);
    endtask : pulse_done
    task automatic final_report;
        $display("checks %0d errors %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : final_report

    initial
    begin
        repeat (3) @(negedge mclk_i);
        resetn_i = 1'h1;
        rd(1'h0, 16'h0000);
        error_interrupt_enable_i = 1'h1;
        for (k = 1; k < 4; k++)
        begin
            d = $random(seed);
            wr_err(k[1:0], d);
            rd(1'h0, exp_err);
        end
        repeat (2) @(negedge mclk_i);
        chk({15'h0, irq_vector_b_o}, {15'h0, |exp_err[6:0]});
        error_interrupt_enable_i = 1'h0;
        repeat (2) @(negedge mclk_i);
        chk({15'h0, irq_vector_b_o}, 16'h0000);
        error_interrupt_enable_i = 1'h1;
        // Write and read back each secondary, then read all again so a read of the wrong one shows up
        for (k = 0; k < 32; k++)
        begin
            wr_err(2'h3, {4'h0, k[3:0], 8'h00});
            if (k < 16)
            begin
                d = $random(seed);
                sec_m[k] = (k == 8 || k == 9) ? 16'h0000 : d;
                acc(1'h1, 1'h1, 2'h3, d);
                acc(1'h1, 1'h1, 2'h1, ~d);
            end
            rd(1'h1, sec_m[k[3:0]]);
        end
        // Error k sets bit k; the clock cases also start the run with no clock
        for (k = 0; k < 7; k++)
        begin
            wr_err(2'h3, 16'h0000);
            sd = k[0] | (k == 6);
            clk_on[sd] = (k > 1);
            rset[sd] = 1'h1;
            @(negedge mclk_i);
            rset = 2'h0;
            nxm[sd] = (k == 4 || k == 5);
            dly = (k < 4) ? 8'hC8 : 8'h03;
            req[sd] = (k > 1 && k < 6);
            if (k == 2 || k == 3)
            begin
                char_bits_i = sd ? 4'h8 : 4'h9;
                repeat (sd ? 1 : 0) pulse_done(sd);
                chk({15'h0, sd ? rx_run_o : tx_run_o}, 16'h0001);
                pulse_done(sd);
            end
            receive_block_check_accum_mismatch_i = (k == 6);
            @(negedge mclk_i);
            receive_block_check_accum_mismatch_i = 1'h0;
            chk({15'h0, receive_block_check_accum_clr_o}, {15'h0, k == 6});
            repeat (30) @(negedge mclk_i);
            {req, nxm, clk_on} = 6'h03;
            exp_err = 16'h0001 << k;
            rd(1'h0, exp_err);
            chk({15'h0, sd ? rx_run_o : tx_run_o}, {15'h0, k == 6});
            // Receiver finishes one more character after a check mismatch; receiver must still be running
            if (k == 6) pulse_done(1'h1);
            chk({15'h0, rx_run_o}, {15'h0, k == 6});
        end
        for (k = 0; k < 2; k++)
        begin
            rset = 2'h3;
            @(negedge mclk_i);
            rset = 2'h0;
            wr_err(2'h3, 16'h0F7F);
            chk({14'h0, tx_run_o, rx_run_o}, 16'h0000);
            {master_clear_i, bus_init_i} = k[0] ? 2'h2 : 2'h1;
            @(negedge mclk_i);
            {master_clear_i, bus_init_i} = 2'h0;
            exp_err = 16'h0000;
            rd(1'h0, exp_err);
        end
        final_report;
    end

    initial
    begin
        #100000;
        error_cnt++;
        final_report;
    end
endmodule : sync_line_error_pointer_register_tb_top
